//--- verilog/doe_pkg.sv
// package: constants and types for the double-operand execute block
`default_nettype none
package doe_pkg;
    // register map, byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_SR = 8'h08;
    localparam logic [7:0] OFS_RSEL = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h18;
    localparam int CTRL_START = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ILLEGAL = 2;
    // status register bit positions
    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_N = 2;
    localparam int SR_GIE = 3;
    localparam int SR_CORE_HALT_BIT = 4;
    localparam int SR_OSCILLATOR_OFF_BIT = 5;
    localparam int SR_V = 8;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SR = 4'h2;
    localparam logic [3:0] REG_CG2 = 4'h3;
    // addressing modes
    localparam logic [1:0] AM_REG = 2'h0;
    localparam logic [1:0] AM_IDX = 2'h1;
    localparam logic [1:0] AM_IND = 2'h2;
    localparam logic [1:0] AM_INC = 2'h3;
    // instruction word fields
    localparam int F_OP = 12;
    localparam int F_SREG = 8;
    localparam int F_AD = 7;
    localparam int F_BW = 6;
    localparam int F_AS = 4;
    localparam int F_DREG = 0;
    localparam int BYTE_MSB = 7;
    localparam int WORD_MSB = 15;
    localparam int DIGIT_W = 4;
    localparam int DIGITS = 4;
    localparam logic [15:0] BYTE_MASK = 16'h00FF;
    localparam logic [15:0] WORD_MASK = 16'hFFFF;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] CG_4 = 16'h0004;
    localparam logic [15:0] CG_8 = 16'h0008;
    localparam logic [15:0] CG_0 = 16'h0000;
    localparam logic [15:0] CG_1 = 16'h0001;
    localparam logic [15:0] CG_2 = 16'h0002;
    localparam logic [15:0] CG_M1 = 16'hFFFF;
    localparam logic [4:0] BCD_MAX = 5'h09;
    localparam logic [4:0] BCD_ADJ = 5'h06;
    typedef enum logic [3:0] {
        OP_COPY = 4'h4, OP_SUM = 4'h5, OP_SUMC = 4'h6, OP_DIFFB = 4'h7,
        OP_DIFF = 4'h8, OP_CMP = 4'h9, OP_DSUM = 4'hA, OP_TEST = 4'hB,
        OP_CLRM = 4'hC, OP_SETM = 4'hD, OP_XOR = 4'hE, OP_AND = 4'hF
    } doe_op_t;
    typedef enum logic [8:0] {
        S_IDLE = 9'h001, S_FETCH = 9'h002, S_DECODE = 9'h004,
        S_SRC_EXT = 9'h008, S_SRC_RD = 9'h010, S_DST_EXT = 9'h020,
        S_DST_RD = 9'h040, S_EXEC = 9'h080, S_WRITE = 9'h100
    } doe_state_t;
    typedef struct packed {
        logic cyc;
        logic we;
        logic byte_op;
        logic [15:0] adr;
        logic [15:0] wdata;
    } doe_mem_req_t;
endpackage : doe_pkg
`default_nettype wire

//--- verilog/doe_execute.sv
// double-operand execute engine with wishbone register slave
// ==========================================================
// Notes on behaviour
// - immediate read via PC, PC steps past
// - immediate constant moved to destination address
// - one to three words; constants need none
// - immediate mode only for source operand
// - decode 12 double-operand opcodes, lower ones illegal, emulated map
// - every operation is byte or word
// - size bit 0 word, 1 byte
// - source from source mode and register
// - destination from destination mode and register
// - any destination address accepted, written blindly
// - copy writes source, flags untouched
// - sum and carried sum update four flags
// - difference adds inverted source plus one/carry
// - compare computes difference, stores nothing
// - decimal sum with carry, flags updated
// - conjunction writes AND, clears overflow
// - mask test flags like conjunction, no store
// - clear mask writes inverted source AND
// - set mask writes OR, flags untouched
// - exclusive or writes XOR, updates flags
// - flags mean negative, zero, carry, overflow
// - conjunction carry is inverse of zero
// - mode bits altered only when SR is the destination register or is written over the bus
`default_nettype none
module doe_execute (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output doe_pkg::doe_mem_req_t mem_req,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);
    // ==========================================================
    // state
    doe_pkg::doe_state_t st, next_st;
    logic [15:0] regs [16];
    logic [15:0] next_regs [16];
    logic [15:0] ir, next_ir, src_v, next_src, dst_v, next_dst;
    logic [15:0] ea, next_ea, res, next_res;
    logic done, next_done, illegal, next_illegal;
    doe_pkg::doe_mem_req_t next_mem;
    logic [31:0] next_dat;
    logic next_ack;
    logic [3:0] rsel, next_rsel;

    // instruction fields
    logic [3:0] op, sreg, dreg;
    logic [1:0] as_m;
    logic ad, bw;
    assign op = ir[doe_pkg::F_OP +: 4];
    assign sreg = ir[doe_pkg::F_SREG +: 4];
    assign dreg = ir[doe_pkg::F_DREG +: 4];
    assign as_m = ir[doe_pkg::F_AS +: 2];
    assign ad = ir[doe_pkg::F_AD];
    assign bw = ir[doe_pkg::F_BW];

    logic [15:0] bmask, step, wmask;
    logic busy, bus_wr, start, clr_done, imm;
    assign bmask = bw ? doe_pkg::BYTE_MASK : doe_pkg::WORD_MASK;
    assign step = bw ? doe_pkg::BYTE_STEP : doe_pkg::WORD_STEP;
    assign imm = (as_m == doe_pkg::AM_INC) && (sreg == doe_pkg::REG_PC);
    assign busy = (st != doe_pkg::S_IDLE);
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign start = bus_wr && !busy && (wb_adr_i == doe_pkg::OFS_CTRL)
        && wb_sel_i[0] && wb_dat_i[doe_pkg::CTRL_START];
    assign clr_done = bus_wr && (wb_adr_i == doe_pkg::OFS_STATUS)
        && wb_sel_i[0] && wb_dat_i[doe_pkg::ST_DONE];

    function automatic doe_pkg::doe_mem_req_t req(input logic [15:0] a,
        input logic w, input logic b, input logic [15:0] d);
        doe_pkg::doe_mem_req_t r;
        r.cyc = 1'b1;
        r.we = w;
        r.byte_op = b;
        r.adr = a;
        r.wdata = d;
        return r;
    endfunction : req

    // ==========================================================
    // decimal digit chain
    logic [doe_pkg::DIGITS:0] bcd_c;
    logic [15:0] bcd_sum;
    assign bcd_c[0] = regs[doe_pkg::REG_SR][doe_pkg::SR_C];
    for (genvar g = 0; g < doe_pkg::DIGITS; g++) begin : g_bcd
        logic [4:0] raw;
        logic [4:0] adj;
        assign raw = {1'b0, dst_v[g*doe_pkg::DIGIT_W +: 4]}
            + {1'b0, src_v[g*doe_pkg::DIGIT_W +: 4]} + {4'h0, bcd_c[g]};
        assign bcd_c[g+1] = (raw > doe_pkg::BCD_MAX);
        assign adj = raw + doe_pkg::BCD_ADJ;
        assign bcd_sum[g*doe_pkg::DIGIT_W +: 4] = bcd_c[g+1] ? adj[3:0] : raw[3:0];
    end

    // ==========================================================
    // arithmetic and logic unit
    logic [15:0] addend, alu_res;
    localparam logic [15:0] CG_ZERO = doe_pkg::CG_0;
    logic [16:0] sum17;
    logic cin, msb_a, msb_b, msb_r, fl_v, fl_c, fl_z, fl_n, upd, wr;
    always_comb begin
        addend = src_v;
        cin = 1'b0;
        upd = 1'b1;
        wr = 1'b1;
        case (op)
            doe_pkg::OP_SUMC: cin = regs[doe_pkg::REG_SR][doe_pkg::SR_C];
            doe_pkg::OP_DIFF, doe_pkg::OP_CMP: begin
                addend = ~src_v;
                cin = 1'b1;
            end
            doe_pkg::OP_DIFFB: begin
                addend = ~src_v;
                cin = regs[doe_pkg::REG_SR][doe_pkg::SR_C];
            end
            default: cin = 1'b0;
        endcase
        sum17 = {1'b0, dst_v & bmask} + {1'b0, addend & bmask} + {16'h0000, cin};
        msb_a = bw ? dst_v[doe_pkg::BYTE_MSB] : dst_v[doe_pkg::WORD_MSB];
        msb_b = bw ? addend[doe_pkg::BYTE_MSB] : addend[doe_pkg::WORD_MSB];
        alu_res = sum17[15:0] & bmask;
        fl_c = bw ? sum17[doe_pkg::BYTE_MSB+1] : sum17[doe_pkg::WORD_MSB+1];
        fl_v = 1'b0;
        case (op)
            doe_pkg::OP_COPY: begin
                alu_res = src_v & bmask;
                upd = 1'b0;
            end
            doe_pkg::OP_DSUM: begin
                alu_res = bcd_sum & bmask;
                fl_c = bw ? bcd_c[doe_pkg::DIGITS/2] : bcd_c[doe_pkg::DIGITS];
            end
            doe_pkg::OP_AND, doe_pkg::OP_TEST: begin
                alu_res = src_v & dst_v & bmask;
                fl_c = |alu_res;
            end
            doe_pkg::OP_CLRM: begin
                alu_res = ~src_v & dst_v & bmask;
                upd = 1'b0;
            end
            doe_pkg::OP_SETM: begin
                alu_res = (src_v | dst_v) & bmask;
                upd = 1'b0;
            end
            doe_pkg::OP_XOR: begin
                alu_res = (src_v ^ dst_v) & bmask;
                fl_c = |alu_res;
                fl_v = msb_a && msb_b;
            end
            default: fl_v = 1'b0;
        endcase
        msb_r = bw ? alu_res[doe_pkg::BYTE_MSB] : alu_res[doe_pkg::WORD_MSB];
        if (op == doe_pkg::OP_SUM || op == doe_pkg::OP_SUMC || op == doe_pkg::OP_DIFF
            || op == doe_pkg::OP_DIFFB || op == doe_pkg::OP_CMP) begin
            fl_v = (msb_a == msb_b) && (msb_r != msb_a);
        end
        fl_n = msb_r;
        fl_z = (alu_res == CG_ZERO);
        if (op == doe_pkg::OP_CMP || op == doe_pkg::OP_TEST) begin
            wr = 1'b0;
        end
    end

    // ==========================================================
    // execution sequencer
    logic go_dst, set_done;
    always_comb begin
        next_st = st;
        next_regs = regs;
        next_ir = ir;
        next_src = src_v;
        next_dst = dst_v;
        next_ea = ea;
        next_res = res;
        next_mem = mem_req;
        next_illegal = illegal;
        go_dst = 1'b0;
        set_done = 1'b0;
        if (bus_wr && !busy) begin
            if (wb_adr_i == doe_pkg::OFS_PC) begin
                next_regs[doe_pkg::REG_PC] = (regs[doe_pkg::REG_PC] & ~wmask)
                    | (wb_dat_i[15:0] & wmask);
            end else if (wb_adr_i == doe_pkg::OFS_SR) begin
                next_regs[doe_pkg::REG_SR] = (regs[doe_pkg::REG_SR] & ~wmask)
                    | (wb_dat_i[15:0] & wmask);
            end else if (wb_adr_i == doe_pkg::OFS_RDATA) begin
                next_regs[rsel] = (regs[rsel] & ~wmask) | (wb_dat_i[15:0] & wmask);
            end
        end
        case (st)
            doe_pkg::S_IDLE: begin
                if (start) begin
                    next_st = doe_pkg::S_FETCH;
                    next_illegal = 1'b0;
                end
            end
            doe_pkg::S_FETCH: begin
                if (!mem_req.cyc) begin
                    next_mem = req(regs[doe_pkg::REG_PC], 1'b0, 1'b0, CG_ZERO);
                end else if (mem_ack) begin
                    next_mem.cyc = 1'b0;
                    next_ir = mem_rdata;
                    next_regs[doe_pkg::REG_PC] = regs[doe_pkg::REG_PC] + doe_pkg::WORD_STEP;
                    next_st = doe_pkg::S_DECODE;
                end
            end
            doe_pkg::S_DECODE: begin
                if (op < doe_pkg::OP_COPY) begin
                    next_illegal = 1'b1;
                    set_done = 1'b1;
                    next_st = doe_pkg::S_IDLE;
                end else if (sreg == doe_pkg::REG_CG2) begin
                    case (as_m)
                        doe_pkg::AM_REG: next_src = doe_pkg::CG_0;
                        doe_pkg::AM_IDX: next_src = doe_pkg::CG_1;
                        doe_pkg::AM_IND: next_src = doe_pkg::CG_2;
                        default: next_src = doe_pkg::CG_M1 & bmask;
                    endcase
                    go_dst = 1'b1;
                end else if (sreg == doe_pkg::REG_SR && as_m == doe_pkg::AM_IND) begin
                    next_src = doe_pkg::CG_4;
                    go_dst = 1'b1;
                end else if (sreg == doe_pkg::REG_SR && as_m == doe_pkg::AM_INC) begin
                    next_src = doe_pkg::CG_8;
                    go_dst = 1'b1;
                end else if (as_m == doe_pkg::AM_REG) begin
                    next_src = regs[sreg] & bmask;
                    go_dst = 1'b1;
                end else if (as_m == doe_pkg::AM_IDX || imm) begin
                    next_st = doe_pkg::S_SRC_EXT;
                end else begin
                    next_ea = regs[sreg];
                    if (as_m == doe_pkg::AM_INC) begin
                        next_regs[sreg] = regs[sreg] + step;
                    end
                    next_st = doe_pkg::S_SRC_RD;
                end
            end
            doe_pkg::S_SRC_EXT: begin
                if (!mem_req.cyc) begin
                    next_mem = req(regs[doe_pkg::REG_PC], 1'b0, 1'b0, CG_ZERO);
                end else if (mem_ack) begin
                    next_mem.cyc = 1'b0;
                    next_regs[doe_pkg::REG_PC] = regs[doe_pkg::REG_PC] + doe_pkg::WORD_STEP;
                    if (imm) begin
                        next_src = mem_rdata & bmask;
                        go_dst = 1'b1;
                    end else begin
                        next_ea = mem_rdata
                            + ((sreg == doe_pkg::REG_SR) ? CG_ZERO : regs[sreg]);
                        next_st = doe_pkg::S_SRC_RD;
                    end
                end
            end
            doe_pkg::S_SRC_RD: begin
                if (!mem_req.cyc) begin
                    next_mem = req(ea, 1'b0, bw, CG_ZERO);
                end else if (mem_ack) begin
                    next_mem.cyc = 1'b0;
                    next_src = mem_rdata & bmask;
                    go_dst = 1'b1;
                end
            end
            doe_pkg::S_DST_EXT: begin
                if (!mem_req.cyc) begin
                    next_mem = req(regs[doe_pkg::REG_PC], 1'b0, 1'b0, CG_ZERO);
                end else if (mem_ack) begin
                    next_mem.cyc = 1'b0;
                    next_regs[doe_pkg::REG_PC] = regs[doe_pkg::REG_PC] + doe_pkg::WORD_STEP;
                    next_ea = mem_rdata
                        + ((dreg == doe_pkg::REG_SR) ? CG_ZERO : regs[dreg]);
                    next_st = (op == doe_pkg::OP_COPY) ? doe_pkg::S_EXEC : doe_pkg::S_DST_RD;
                end
            end
            doe_pkg::S_DST_RD: begin
                if (!mem_req.cyc) begin
                    next_mem = req(ea, 1'b0, bw, CG_ZERO);
                end else if (mem_ack) begin
                    next_mem.cyc = 1'b0;
                    next_dst = mem_rdata & bmask;
                    next_st = doe_pkg::S_EXEC;
                end
            end
            doe_pkg::S_EXEC: begin
                next_res = alu_res;
                if (upd) begin
                    next_regs[doe_pkg::REG_SR][doe_pkg::SR_C] = fl_c;
                    next_regs[doe_pkg::REG_SR][doe_pkg::SR_Z] = fl_z;
                    next_regs[doe_pkg::REG_SR][doe_pkg::SR_N] = fl_n;
                    next_regs[doe_pkg::REG_SR][doe_pkg::SR_V] = fl_v;
                end
                if (wr && ad) begin
                    next_st = doe_pkg::S_WRITE;
                end else begin
                    if (wr) begin
                        next_regs[dreg] = alu_res;
                    end
                    set_done = 1'b1;
                    next_st = doe_pkg::S_IDLE;
                end
            end
            doe_pkg::S_WRITE: begin
                if (!mem_req.cyc) begin
                    next_mem = req(ea, 1'b1, bw, res);
                end else if (mem_ack) begin
                    next_mem.cyc = 1'b0;
                    set_done = 1'b1;
                    next_st = doe_pkg::S_IDLE;
                end
            end
            default: next_st = doe_pkg::S_IDLE;
        endcase
        if (go_dst) begin
            if (!ad) begin
                next_dst = next_regs[dreg] & bmask;
                next_st = doe_pkg::S_EXEC;
            end else begin
                next_st = doe_pkg::S_DST_EXT;
            end
        end
        next_done = (done && !clr_done) || set_done;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= doe_pkg::S_IDLE;
            for (int i = 0; i < 16; i++) begin
                regs[i] <= doe_pkg::REG_RESET;
            end
            ir <= doe_pkg::REG_RESET;
            src_v <= doe_pkg::REG_RESET;
            dst_v <= doe_pkg::REG_RESET;
            ea <= doe_pkg::REG_RESET;
            res <= doe_pkg::REG_RESET;
            mem_req <= '0;
            done <= 1'b0;
            illegal <= 1'b0;
        end else begin
            st <= next_st;
            regs <= next_regs;
            ir <= next_ir;
            src_v <= next_src;
            dst_v <= next_dst;
            ea <= next_ea;
            res <= next_res;
            mem_req <= next_mem;
            done <= next_done;
            illegal <= next_illegal;
        end
    end

    // ==========================================================
    // wishbone slave
    always_comb begin
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_rsel = rsel;
        next_dat = 32'h0000_0000;
        if (bus_wr && wb_adr_i == doe_pkg::OFS_RSEL && wb_sel_i[0]) begin
            next_rsel = wb_dat_i[3:0];
        end
        if (wb_adr_i == doe_pkg::OFS_PC) begin
            next_dat[15:0] = regs[doe_pkg::REG_PC];
        end else if (wb_adr_i == doe_pkg::OFS_SR) begin
            next_dat[15:0] = regs[doe_pkg::REG_SR];
        end else if (wb_adr_i == doe_pkg::OFS_RSEL) begin
            next_dat[3:0] = rsel;
        end else if (wb_adr_i == doe_pkg::OFS_RDATA) begin
            next_dat[15:0] = regs[rsel];
        end else if (wb_adr_i == doe_pkg::OFS_STATUS) begin
            next_dat[doe_pkg::ST_BUSY] = busy;
            next_dat[doe_pkg::ST_DONE] = done;
            next_dat[doe_pkg::ST_ILLEGAL] = illegal;
        end else if (wb_adr_i == doe_pkg::OFS_RESULT) begin
            next_dat[15:0] = res;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            rsel <= 4'h0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            rsel <= next_rsel;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence imm_ext_done;
        st == doe_pkg::S_SRC_EXT && mem_req.cyc && mem_ack && imm;
    endsequence
    sequence dst_ext_done;
        st == doe_pkg::S_DST_EXT && mem_req.cyc && mem_ack;
    endsequence

    chk_imm_pc_step: assert property (imm_ext_done |=>
        regs[doe_pkg::REG_PC] == $past(regs[doe_pkg::REG_PC]) + doe_pkg::WORD_STEP)
        else $error("pc not advanced past immediate word");
    chk_imm_src_value: assert property (imm_ext_done |=>
        src_v == ($past(mem_rdata) & bmask))
        else $error("immediate constant not taken as source");
    chk_dst_ext_next: assert property (dst_ext_done |=>
        (st == doe_pkg::S_EXEC || st == doe_pkg::S_DST_RD) && !mem_req.cyc)
        else $error("destination extension not followed by access");
    chk_copy_flags: assert property ((st == doe_pkg::S_EXEC && op == doe_pkg::OP_COPY)
        |=> $stable(regs[doe_pkg::REG_SR]) || dreg == doe_pkg::REG_SR)
        else $error("copy altered status flags");
    chk_cmp_no_store: assert property ((st == doe_pkg::S_EXEC && op == doe_pkg::OP_CMP)
        |=> st == doe_pkg::S_IDLE && !mem_req.cyc
        && (dreg == doe_pkg::REG_SR || $stable(regs[dreg])))
        else $error("compare stored a result");
    localparam logic [15:0] CG_1_W = doe_pkg::CG_1;
    chk_diff_formula: assert property ((st == doe_pkg::S_EXEC && op == doe_pkg::OP_DIFF)
        |-> alu_res == ((dst_v + ~src_v + CG_1_W) & bmask))
        else $error("difference result wrong");
    chk_and_carry: assert property ((st == doe_pkg::S_EXEC && op == doe_pkg::OP_AND
        && !(dreg == doe_pkg::REG_SR && !ad)) |=>
        regs[doe_pkg::REG_SR][doe_pkg::SR_C] == !regs[doe_pkg::REG_SR][doe_pkg::SR_Z]
        && !regs[doe_pkg::REG_SR][doe_pkg::SR_V])
        else $error("conjunction carry or overflow wrong");
    chk_mode_bits: assert property ((st == doe_pkg::S_EXEC
        && !(dreg == doe_pkg::REG_SR && !ad)) |=>
        $stable(regs[doe_pkg::REG_SR][doe_pkg::SR_OSCILLATOR_OFF_BIT:doe_pkg::SR_GIE]))
        else $error("mode bits altered");
    chk_byte_neg: assert property ((st == doe_pkg::S_EXEC && bw && upd
        && !(dreg == doe_pkg::REG_SR && !ad)) |=>
        regs[doe_pkg::REG_SR][doe_pkg::SR_N] == $past(alu_res[doe_pkg::BYTE_MSB]))
        else $error("byte negative flag not from bit seven");
    chk_sum_store: assert property ((st == doe_pkg::S_EXEC && op == doe_pkg::OP_SUM
        && !ad && dreg != doe_pkg::REG_SR) |=>
        regs[$past(dreg)] == $past(alu_res))
        else $error("sum not stored to register");
endmodule : doe_execute
`default_nettype wire

//--- bench/doe_mem_model.sv
// core bus memory model answering the execute engine
`default_nettype none
module doe_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire doe_pkg::doe_mem_req_t req,
    output logic [15:0] rdata,
    output logic ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:255];
    logic [1:0] cnt;
    logic slow;
    // alternates prompt and slow answers; any address is written
    always @(posedge clk) begin
        ack <= 1'b0;
        if (rst) begin
            cnt <= 2'h0;
            slow <= 1'b0;
            rdata <= 16'h0000;
        end else if (req.cyc && !ack && cnt == {slow, 1'b0}) begin
            ack <= 1'b1;
            cnt <= 2'h0;
            slow <= ~slow;
            rdata <= mem[req.adr[8:1]];
            if (req.we) begin
                mem[req.adr[8:1]] <= req.wdata;
            end
        end else begin
            cnt <= (req.cyc && !ack) ? cnt + 2'h1 : 2'h0;
            rdata <= ~rdata;
        end
    end
endmodule : doe_mem_model
`default_nettype wire

//--- bench/double_operand_execute_tb_top.sv
// testbench for the double-operand execute block
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module double_operand_execute_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, mem_ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat;
    logic [15:0] q, mem_rdata;
    doe_pkg::doe_mem_req_t mem_req;
    int errors = 0, checks_done = 0;
    doe_execute doe_execute_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    doe_mem_model doe_mem_model_i (.clk(clk), .rst(rst), .req(mem_req), .rdata(mem_rdata),
        .ack(mem_ack));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic run(input logic [15:0] ins, input logic [15:0] e0, input logic [15:0] e1);
        int n;
        doe_mem_model_i.mem[0] = ins;
        doe_mem_model_i.mem[1] = e0;
        doe_mem_model_i.mem[2] = e1;
        wb(1'b1, doe_pkg::OFS_STATUS, 16'h0002);
        wb(1'b1, doe_pkg::OFS_PC, 16'h0000);
        wb(1'b1, doe_pkg::OFS_SR, 16'h0008);
        wb(1'b1, doe_pkg::OFS_CTRL, 16'h0001);
        n = 0;
        q = 16'h0000;
        while (q[1] !== 1'b1 && n < 200) begin
            wb(1'b0, doe_pkg::OFS_STATUS, 16'h0000);
            n++;
        end
        if (n >= 200) errors++;
    endtask : run
    // immediate 8001 against register 8002, every operation, one byte case
    task automatic t_ops;
        logic [4:0] ops [13] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B,
            5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h15};
        logic [15:0] res [13] = '{16'h8001, 16'h0003, 16'h0003, 16'h0000, 16'h0001, 16'h8002,
            16'h6003, 16'h8002, 16'h0002, 16'h8003, 16'h0003, 16'h8000, 16'h0003};
        logic [15:0] srs [13] = '{16'h0008, 16'h0109, 16'h0109, 16'h000B, 16'h0009, 16'h0009,
            16'h0009, 16'h000D, 16'h0008, 16'h0008, 16'h0109, 16'h000D, 16'h0008};
        for (int i = 0; i < 13; i++) begin
            wb(1'b1, doe_pkg::OFS_RSEL, 16'h0004);
            wb(1'b1, doe_pkg::OFS_RDATA, 16'h8002);
            run({ops[i][3:0], 4'h0, 1'b0, ops[i][4], 2'h3, 4'h4}, 16'h8001, 16'h0000);
            wb(1'b0, doe_pkg::OFS_RDATA, 16'h0000);
            `CHK("result", res[i], q)
            wb(1'b0, doe_pkg::OFS_SR, 16'h0000);
            `CHK("flags", srs[i], q)
            wb(1'b0, doe_pkg::OFS_PC, 16'h0000);
            `CHK("pc", 16'h0004, q)
        end
        $display("t_ops done");
    endtask : t_ops
    // immediate copied to an absolute memory destination
    task automatic t_mem_dst;
        run(16'h40B2, 16'h8001, 16'h0100);
        `CHK("memory", 16'h8001, doe_mem_model_i.mem[128])
        wb(1'b0, doe_pkg::OFS_PC, 16'h0000);
        `CHK("pc", 16'h0006, q)
        $display("t_mem_dst done");
    endtask : t_mem_dst
    // illegal top nibble, constant source, autoincrement source to memory destination
    task automatic t_modes;
        run(16'h1000, 16'h0000, 16'h0000);
        wb(1'b0, doe_pkg::OFS_STATUS, 16'h0000);
        `CHK("illegal", 16'h0006, q)
        wb(1'b0, doe_pkg::OFS_PC, 16'h0000);
        `CHK("illegal pc", 16'h0002, q)
        wb(1'b1, doe_pkg::OFS_RSEL, 16'h0004);
        wb(1'b1, doe_pkg::OFS_RDATA, 16'h8002);
        run(16'h5314, 16'h0000, 16'h0000);
        wb(1'b0, doe_pkg::OFS_RDATA, 16'h0000);
        `CHK("cg result", 16'h8003, q)
        wb(1'b0, doe_pkg::OFS_RESULT, 16'h0000);
        `CHK("result reg", 16'h8003, q)
        wb(1'b0, doe_pkg::OFS_SR, 16'h0000);
        `CHK("cg flags", 16'h000C, q)
        wb(1'b0, doe_pkg::OFS_PC, 16'h0000);
        `CHK("cg pc", 16'h0002, q)
        wb(1'b1, doe_pkg::OFS_RSEL, 16'h0006);
        wb(1'b1, doe_pkg::OFS_RDATA, 16'h0100);
        wb(1'b1, doe_pkg::OFS_RSEL, 16'h0005);
        wb(1'b1, doe_pkg::OFS_RDATA, 16'h0100);
        doe_mem_model_i.mem[128] = 16'h8001;
        run(16'h55B6, 16'h0000, 16'h0000);
        `CHK("ind memory", 16'h0002, doe_mem_model_i.mem[128])
        wb(1'b0, doe_pkg::OFS_RDATA, 16'h0000);
        `CHK("autoinc", 16'h0102, q)
        wb(1'b0, doe_pkg::OFS_SR, 16'h0000);
        `CHK("ind flags", 16'h0109, q)
        wb(1'b0, doe_pkg::OFS_PC, 16'h0000);
        `CHK("ind pc", 16'h0004, q)
        $display("t_modes done");
    endtask : t_modes
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_ops;
        t_mem_dst;
        t_modes;
        final_report;
    end
    initial begin
        #200000;
        errors++;
        final_report;
    end
endmodule : double_operand_execute_tb_top
`default_nettype wire
